/* File: ptc_pkg.sv */
// package of constants and types for the period timer counter
package ptc_pkg;
   // ---------------------------------------------------------------
   // control word layout
   // ---------------------------------------------------------------
   localparam int CTRL_W          = 16;       // control word width
   localparam int CNT_W           = 16;       // counter width
   localparam int BIT_TIMER_ON    = 15;       // timer on
   localparam int BIT_STOP_IDLE   = 13;       // stop in idle
   localparam int BIT_GATE_ACC    = 6;        // gate accumulate enable
   localparam int BIT_PRESC_HI    = 5;        // prescale select msb
   localparam int BIT_PRESC_LO    = 4;        // prescale select lsb
   localparam int BIT_EXT_SYNC    = 2;        // external sync select
   localparam int BIT_CLK_SRC     = 1;        // clock source select
   localparam logic [15:0] CTRL_RESET   = 16'h0000; // control after reset
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF; // period after reset
   localparam logic [15:0] COUNT_RESET  = 16'h0000; // count after reset
   localparam logic [7:0]  PRESC_RESET  = 8'h00;    // prescaler after reset
   // ---------------------------------------------------------------
   // prescale terminal counts (ratio minus one)
   // ---------------------------------------------------------------
   localparam logic [7:0] PRESC_TC_1   = 8'h00;
   localparam logic [7:0] PRESC_TC_8   = 8'h07;
   localparam logic [7:0] PRESC_TC_64  = 8'h3F;
   localparam logic [7:0] PRESC_TC_256 = 8'hFF;
   // clock source mode, gray coded
   typedef enum logic [1:0] {
      PTC_MODE_TIMER = 2'b00,
      PTC_MODE_SYNC  = 2'b01,
      PTC_MODE_ASYNC = 2'b11
   } ptc_mode_t;
endpackage

/* File: ptc_tick_if.sv */
// interface carrying the count tick from the prescaler to the counter
`timescale 1ns/1ns
`default_nettype none
interface ptc_tick_if;
   logic tick;    // one-cycle count enable
   logic clear;   // prescaler clear request
   modport src  (output tick, input clear);
   modport sink (input tick, output clear);
endinterface
`default_nettype wire

/* File: ptc_prescaler.sv */
// prescaler dividing the raw count event by 1, 8, 64 or 256
`timescale 1ns/1ns
`default_nettype none
module ptc_prescaler
   import ptc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       rawEvent,
   input  wire logic [1:0] presc,
   ptc_tick_if.src         tk
);
   // ---------------------------------------------------------------
   // divider
   // ---------------------------------------------------------------
   logic [7:0] cnt;   // prescaler count
   logic [7:0] tc;    // terminal count for the chosen ratio

   // ratio decode
   function automatic logic [7:0] tcOf(input logic [1:0] s);
      case (s)
         2'b00:   tcOf = PRESC_TC_1;
         2'b01:   tcOf = PRESC_TC_8;
         2'b10:   tcOf = PRESC_TC_64;
         default: tcOf = PRESC_TC_256;
      endcase
   endfunction

   assign tc = tcOf(presc);
   assign tk.tick = rawEvent && (cnt >= tc);

   // divider count, cleared on request or reset
   always_ff @(posedge clk) begin
      if (rst || tk.clear) begin
         cnt <= PRESC_RESET;
      end else if (rawEvent) begin
         cnt <= (cnt >= tc) ? PRESC_RESET : 8'(cnt + 8'h01);
      end
   end

   // every eighth event ticks at 1:8
   property p_div8;
      @(posedge clk) disable iff (rst)
      (presc == 2'b01 && !tk.clear && rawEvent && cnt == 8'h07) |-> tk.tick;
   endproperty
   a_div8: assert property (p_div8) else $error("no tick at 1:8 terminal");

   property p_clr;
      @(posedge clk) disable iff (rst)
      tk.clear |=> (cnt == PRESC_RESET);
   endproperty
   a_clr: assert property (p_clr) else $error("prescaler not cleared");
endmodule
`default_nettype wire

/* File: ptc_timer.sv */
// 16-bit period timer counter with gating, prescale and idle control
//
// Functional notes
// - 16-bit counter, three clocking modes
// - timer mode counts cycles, wraps at period
// - idle halts timer/sync modes if stop set
// - leaving idle resumes from held count
// - sync mode counts synchronised pin rises
// - async mode counts every pin rise
// - async mode halts in idle if stop set
// - flag on match and gate fall
// - counting continues through idle if stop clear, sleep if async
// - mode, gating, prescale from control word
// - gated mode counts only while pin high
// - prescale 1, 8, 64 or 256
// - prescaler cleared by count write, off
// - sleep counting only async external on
`timescale 1ns/1ns
`default_nettype none
module ptc_timer
   import ptc_pkg::*;
(
   input  wire logic [ptc_pkg::CTRL_W-1:0] timerControl,
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic [ptc_pkg::CNT_W-1:0]  periodValue,
   input  wire logic [ptc_pkg::CNT_W-1:0]  countWriteData,
   input  wire logic                       countWrite,
   input  wire logic                       externalClockGatePin,
   input  wire logic                       cpuIdle,
   input  wire logic                       cpuSleep,
   input  wire logic                       flagClear,
   output logic      [ptc_pkg::CNT_W-1:0]  countValue,
   output logic                            periodMatchFlag,
   output logic                            interruptRequest
);
   import ptc_pkg::*;
   // ---------------------------------------------------------------
   // control decode
   // ---------------------------------------------------------------
   logic       timerOn;      // timer on bit
   logic       stopInIdle;   // stop in idle bit
   logic       gateAcc;      // gate accumulate enable
   logic [1:0] prescSel;     // prescale select
   logic       extSync;      // external sync select
   logic       clkSrc;       // clock source select
   ptc_mode_t  mode;         // decoded clocking mode

   assign timerOn    = timerControl[BIT_TIMER_ON];
   assign stopInIdle = timerControl[BIT_STOP_IDLE];
   assign gateAcc    = timerControl[BIT_GATE_ACC];
   assign prescSel   = timerControl[BIT_PRESC_HI:BIT_PRESC_LO];
   assign extSync    = timerControl[BIT_EXT_SYNC];
   assign clkSrc     = timerControl[BIT_CLK_SRC];

   // mode select from source and sync bits
   always_comb begin
      case ({clkSrc, extSync})
         2'b10:   mode = PTC_MODE_ASYNC;
         2'b11:   mode = PTC_MODE_SYNC;
         default: mode = PTC_MODE_TIMER;
      endcase
   end

   // ---------------------------------------------------------------
   // pin edge detection
   // ---------------------------------------------------------------
   logic pinSync1;   // first sync stage
   logic pinSync2;   // second sync stage
   logic pinLast;    // delayed synced level
   logic pinPrev;    // previous raw level for async edges
   logic syncRise;   // synchronised rising edge
   logic asyncRise;  // unsynchronised rising edge
   logic gateFall;   // falling edge of gate

   // synchroniser and edge history
   always_ff @(posedge clk) begin
      if (rst) begin
         pinSync1 <= 1'b0;
         pinSync2 <= 1'b0;
         pinLast  <= 1'b0;
         pinPrev  <= 1'b0;
      end else begin
         pinSync1 <= externalClockGatePin;
         pinSync2 <= pinSync1;
         pinLast  <= pinSync2;
         pinPrev  <= externalClockGatePin;
      end
   end

   assign syncRise  = pinSync2 && !pinLast;
   assign asyncRise = externalClockGatePin && !pinPrev;
   assign gateFall  = !pinSync2 && pinLast;

   // ---------------------------------------------------------------
   // run qualification
   // ---------------------------------------------------------------
   logic idleHalt;   // counting stopped by idle
   logic sleepOk;    // counting allowed in sleep
   logic runOk;      // counter may advance
   logic rawEvent;   // raw count event before prescale

   // idle halts every mode when stop bit set; resumes on exit
   assign idleHalt = cpuIdle && stopInIdle;
   // in sleep only the async external mode runs
   assign sleepOk  = !cpuSleep || mode == PTC_MODE_ASYNC;
   assign runOk    = timerOn && !idleHalt && sleepOk;

   // source event per mode
   always_comb begin
      case (mode)
         PTC_MODE_TIMER: rawEvent = !gateAcc || pinSync2;
         PTC_MODE_SYNC:  rawEvent = syncRise;
         PTC_MODE_ASYNC: rawEvent = asyncRise;
         default:        rawEvent = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // prescaler
   // ---------------------------------------------------------------
   ptc_tick_if tk ();
   logic       onLast;   // timer on delayed, to see it cleared

   always_ff @(posedge clk) begin
      if (rst) begin
         onLast <= 1'b0;
      end else begin
         onLast <= timerOn;
      end
   end

   // clear on count write or timer on falling
   assign tk.clear = countWrite || (onLast && !timerOn);

   ptc_prescaler ptc_prescaler_i (
      .clk      (clk),
      .rst      (rst),
      .rawEvent (rawEvent && runOk),
      .presc    (prescSel),
      .tk       (tk)
   );

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   logic wrap;   // count reaches period on this tick

   assign wrap = tk.tick && !countWrite && (countValue == periodValue);

   // count register; writes take priority
   always_ff @(posedge clk) begin
      if (rst) begin
         countValue <= COUNT_RESET;
      end else if (countWrite) begin
         countValue <= countWriteData;
      end else if (wrap) begin
         countValue <= COUNT_RESET;
      end else if (tk.tick) begin
         countValue <= CNT_W'(countValue + 16'h0001);
      end
   end

   // ---------------------------------------------------------------
   // flag
   // ---------------------------------------------------------------
   logic gateEvent;   // gate fall in gated timer mode

   assign gateEvent = gateAcc && timerOn && mode == PTC_MODE_TIMER && gateFall;

   // sticky flag; set wins over clear
   always_ff @(posedge clk) begin
      if (rst) begin
         periodMatchFlag <= 1'b0;
      end else if (wrap || gateEvent) begin
         periodMatchFlag <= 1'b1;
      end else if (flagClear) begin
         periodMatchFlag <= 1'b0;
      end
   end

   assign interruptRequest = periodMatchFlag;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_wrap;
      tk.tick && !countWrite && countValue == periodValue;
   endsequence

   property p_wrapZero;
      @(posedge clk) disable iff (rst)
      s_wrap |=> (countValue == 16'h0000 && periodMatchFlag);
   endproperty
   a_wrapZero: assert property (p_wrapZero) else $error("no wrap to zero");

   property p_flagHold;
      @(posedge clk) disable iff (rst)
      (periodMatchFlag && !flagClear) |=> periodMatchFlag;
   endproperty
   a_flagHold: assert property (p_flagHold) else $error("flag dropped");

   property p_idleHold;
      @(posedge clk) disable iff (rst)
      (cpuIdle && stopInIdle && !countWrite) |=> $stable(countValue);
   endproperty
   a_idleHold: assert property (p_idleHold) else $error("counted in idle");

   property p_sleepHold;
      @(posedge clk) disable iff (rst)
      (cpuSleep && mode != PTC_MODE_ASYNC && !countWrite) |=> $stable(countValue);
   endproperty
   a_sleepHold: assert property (p_sleepHold) else $error("counted in sleep");

   property p_timerStep;
      @(posedge clk) disable iff (rst)
      (tk.tick && !countWrite && countValue != periodValue)
         |=> countValue == $past(countValue) + 16'h0001;
   endproperty
   a_timerStep: assert property (p_timerStep) else $error("bad increment");

   property p_gateLow;
      @(posedge clk) disable iff (rst)
      (mode == PTC_MODE_TIMER && gateAcc && !pinSync2 && !countWrite) |=> $stable(countValue);
   endproperty
   a_gateLow: assert property (p_gateLow) else $error("counted with gate low");

   property p_gateFlag;
      @(posedge clk) disable iff (rst)
      gateEvent |=> periodMatchFlag;
   endproperty
   a_gateFlag: assert property (p_gateFlag) else $error("gate fall lost");

   property p_offHold;
      @(posedge clk) disable iff (rst)
      (!timerOn && !countWrite) |=> $stable(countValue);
   endproperty
   a_offHold: assert property (p_offHold) else $error("counted while off");
endmodule
`default_nettype wire

/* File: ptc_pin_model.sv */
// far-side model: external clock and gate source on the timer pin
`timescale 1ns/1ns
`default_nettype none
module ptc_pin_model (
   input  wire logic run,
   input  wire logic hold,
   output logic      pin
);
   logic osc = 1'b0; // 2.5 MHz clock, toggles only on falling edges of clk
   // ---------------------------------------------------------------
   // clock stands low outside runs; hold forces the gate high
   // ---------------------------------------------------------------
   always #200 osc = run ? !osc : 1'b0;
   assign pin = osc | hold;
endmodule
`default_nettype wire

/* File: ptc_timer_bench.sv */
// self-checking bench for the period timer counter
`timescale 1ns/1ns
`default_nettype none
module ptc_timer_bench;
   import ptc_pkg::*;
   logic        clk, rst, countWrite, cpuIdle, cpuSleep, flagClear;
   logic        run, hold, pin, prevFlag, periodMatchFlag, interruptRequest;
   logic [15:0] timerControl, periodValue, countWriteData, countValue, held;
   int          err_total = 0, num_checks = 0, seed = 8931, cyc = 0, lastRise = 0, e, p;
   int          expQ[$];
   int          ratio[4] = '{1, 8, 64, 256};
   logic [15:0] ctrlT[7] = '{16'hA000, 16'h8000, 16'hA006, 16'h8006, 16'h8002, 16'hA002, 16'h8000};
   bit          slpT[7]  = '{0, 0, 0, 1, 1, 0, 1};
   int          extT[7]  = '{20, 0, 20, 20, 0, 20, 20};
   int          mulT[7]  = '{1, 1, 4, 4, 4, 4, 1};

   ptc_timer ptc_timer_i (.timerControl(timerControl), .clk(clk), .rst(rst), .periodValue(periodValue),
      .countWriteData(countWriteData), .countWrite(countWrite), .externalClockGatePin(pin),
      .cpuIdle(cpuIdle), .cpuSleep(cpuSleep), .flagClear(flagClear), .countValue(countValue),
      .periodMatchFlag(periodMatchFlag), .interruptRequest(interruptRequest));
   ptc_pin_model ptc_pin_model_i (.run(run), .hold(hold), .pin(pin));

   // ---------------------------------------------------------------
   // clock and cycle counter
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   // compare one value, count and report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic summarize();
      if (err_total == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // load count 0, run k+1 wraps of spacing iv, stall st cycles mid-run
   task automatic runCase(input logic [15:0] ctrl, input int iv, input int k, input int st,
                          input bit slp, input int ext);
      @(negedge clk);
      timerControl = ctrl;
      countWrite = 1'b1;
      expQ.push_back(0);
      expQ.push_back(iv + ext);
      for (int i = 1; i < k; i++) expQ.push_back(iv);
      @(negedge clk);
      countWrite = 1'b0;
      repeat (iv + iv / 2 - 1) @(negedge clk);
      if (st > 0) begin
         cpuIdle = !slp;
         cpuSleep = slp;
         repeat (st) @(negedge clk);
         cpuIdle = 1'b0;
         cpuSleep = 1'b0;
      end
      repeat (k * iv + ext - st) @(negedge clk);
      timerControl = 16'h0000;
      repeat (4) @(negedge clk);
      chk(expQ.size(), 0);
   endtask

   // ---------------------------------------------------------------
   // result watcher: each flag rise takes the oldest expected spacing
   // ---------------------------------------------------------------
   always @(negedge clk) begin
      flagClear <= periodMatchFlag;
      if (!rst && periodMatchFlag === 1'b1 && prevFlag !== 1'b1) begin
         e = (expQ.size() > 0) ? expQ.pop_front() : -1;
         if (e != 0) begin
            chk(cyc - lastRise, e);
            chk(countValue, 16'h0000);
         end
         chk(interruptRequest, 1'b1);
         lastRise = cyc;
      end
      prevFlag <= periodMatchFlag;
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1;
      timerControl = CTRL_RESET;
      periodValue = 16'h0009;
      countWriteData = 16'h0000;
      {countWrite, cpuIdle, cpuSleep, run, hold} = 5'h00;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk(countValue, COUNT_RESET);
      chk(periodMatchFlag, 1'b0);
      // timer mode under every prescale code, random period
      for (int s = 0; s < 4; s++) begin
         p = 7 + ($random(seed) & 7);
         periodValue = 16'(p);
         runCase(16'h8000 | 16'(s << 4), (p + 1) * ratio[s], 2, 0, 0, 0);
      end
      // idle and sleep stalls across the three modes
      periodValue = 16'h0009;
      for (int m = 0; m < 7; m++) begin
         run = mulT[m] > 1;
         runCase(ctrlT[m], 10 * mulT[m], 2, 20, slpT[m], extT[m]);
      end
      run = 1'b0;
      // gated accumulation: count only while high, flag on gate fall
      periodValue = 16'hFFFF;
      timerControl = 16'h8040;
      countWriteData = 16'h0100;
      countWrite = 1'b1;
      @(negedge clk);
      countWrite = 1'b0;
      expQ.push_back(0);
      hold = 1'b1;
      repeat (10) @(negedge clk);
      hold = 1'b0;
      repeat (6) @(negedge clk);
      chk(countValue, 16'h010A);
      held = countValue;
      repeat (10) @(negedge clk);
      chk(countValue, held);
      chk(expQ.size(), 0);
      summarize();
   end

   // watchdog well beyond the longest expected run
   initial begin
      #9000000;
      err_total++;
      summarize();
   end
endmodule
`default_nettype wire
